/* inc/amu_pkg.sv */
// Package of constants, opcode map and carrier types for the addressing mode unit
// Functional notes
// - Direct mode takes the data address from an instruction byte.
// - Pointer-indirect mode addresses data memory through the selected pointer.
// - Post-modify mode accesses at the pointer, then steps it by one.
// - Immediate mode fetches the operand byte following the opcode.
// - Short load puts the opcode nibble into the first pointer, high nibble cleared.
// - Table load reads program memory at upper byte plus accumulator into accumulator.
// - Program counter is 15 bits from upper and lower bytes.
// - Relative jump adds a six-bit displacement, range -32 to +31, to the address after the opcode.
// - Absolute jump loads twelve low bits, keeps the upper three bits.
// - Long jump loads all fifteen counter bits from the instruction.
// - Table jump reads program memory at upper byte plus accumulator into the lower byte.
// - Most single-byte instructions complete in one instruction cycle.
// - Any single bit of data memory can be set, cleared or tested.
// - Three pointers exist: two for indirect addressing, one stack pointer.
// - Vector select loads a two-byte vector from program memory into the counter.
// - A failed test makes the following instruction a no-operation.
`default_nettype none
package amu_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PC_W = 15;
	localparam int DM_AW = 8;
	localparam int PTR_N = 3;

	// ----------------------------------------------------------------
	// Pointer indices and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PTR_FIRST = 2'h0;
	localparam logic [1:0] PTR_SECOND = 2'h1;
	localparam logic [1:0] PTR_STACK = 2'h2;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;

	// ----------------------------------------------------------------
	// Opcode map
	// ----------------------------------------------------------------
	localparam logic [1:0] OPG_REL = 2'h3;
	localparam logic [3:0] OPG_ABS = 4'h2;
	localparam logic [3:0] OPG_SHORT = 4'h5;
	localparam logic [3:0] OPG_BIT = 4'h6;
	localparam logic [3:0] OPG_TEST = 4'h7;
	localparam logic [3:0] OPG_IND = 4'h9;
	localparam logic [7:0] OP_LD_DIR = 8'h80;
	localparam logic [7:0] OP_LD_IMM = 8'h81;
	localparam logic [7:0] OP_TABLE_LOAD = 8'hA4;
	localparam logic [7:0] OP_TABLE_JUMP = 8'hA5;
	localparam logic [7:0] OP_LONG_JUMP = 8'hA6;
	localparam logic [7:0] OP_LD_SECOND = 8'hA8;
	localparam logic [7:0] OP_LD_STACK = 8'hA9;
	localparam logic [7:0] OP_VECTOR = 8'hB4;
	localparam logic [1:0] MOD_NONE = 2'h0;
	localparam logic [1:0] MOD_INC = 2'h1;
	localparam logic [1:0] MOD_DEC = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		C_NOP = 4'h0, C_REL = 4'h1, C_ABS = 4'h2, C_SHORT = 4'h3,
		C_IND = 4'h4, C_DIR = 4'h5, C_IMM = 4'h6, C_LDX = 4'h7,
		C_LDSP = 4'h8, C_TLOAD = 4'h9, C_TJUMP = 4'hA, C_LONG = 4'hB,
		C_VEC = 4'hC, C_SET = 4'hD, C_CLR = 4'hE, C_TEST = 4'hF
	} amu_class_t;

	typedef enum logic [3:0] {
		S_FETCH = 4'h0, S_WAIT = 4'h1, S_OP = 4'h2, S_OPND = 4'h3,
		S_OPND2 = 4'h4, S_DREAD = 4'h5, S_RMW = 4'h6, S_TABLE = 4'h7,
		S_VEC1 = 4'h8, S_VEC2 = 4'h9
	} amu_state_t;

	typedef struct packed {
		logic [7:0] stack;
		logic [7:0] second;
		logic [7:0] first;
	} amu_ptrs_t;

	typedef struct packed {
		logic [DM_AW-1:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} amu_dm_req_t;
endpackage : amu_pkg
`default_nettype wire

/* design/amu_ptr_file.sv */
// Pointer register file holding the two indirect pointers and the stack pointer
`timescale 1ns/1ps
`default_nettype none
module amu_ptr_file (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Write port
	input wire logic wr_en,
	input wire logic [1:0] wr_sel,
	input wire logic [7:0] wr_data,
	// Registered contents
	output amu_pkg::amu_ptrs_t ptrs_r
);
	amu_pkg::amu_ptrs_t ptrs_nxt;

	always_comb begin
		ptrs_nxt = ptrs_r;
		if (wr_en) begin
			case (wr_sel)
				amu_pkg::PTR_FIRST: ptrs_nxt.first = wr_data;
				amu_pkg::PTR_SECOND: ptrs_nxt.second = wr_data;
				amu_pkg::PTR_STACK: ptrs_nxt.stack = wr_data;
				default: ptrs_nxt = ptrs_r;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ptrs_r <= '{stack: amu_pkg::PTR_RST, second: amu_pkg::PTR_RST,
				first: amu_pkg::PTR_RST};
		end else begin
			ptrs_r <= ptrs_nxt;
		end
	end
endmodule : amu_ptr_file
`default_nettype wire

/* design/amu_core.sv */
// Operand address generation and program counter sequencing
`timescale 1ns/1ps
`default_nettype none
module amu_core (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Program memory
	output logic [amu_pkg::PC_W-1:0] pm_addr_r,
	output logic pm_rd_r,
	input wire logic [7:0] pm_rdata,
	// Data memory
	output amu_pkg::amu_dm_req_t dm_req_r,
	input wire logic [7:0] dm_rdata,
	// Vector source
	input wire logic [amu_pkg::PC_W-1:0] vector_addr,
	// Core state
	output logic [amu_pkg::PC_W-1:0] pc_r,
	output logic [7:0] acc_r,
	output logic skip_r,
	output amu_pkg::amu_ptrs_t ptrs_r
);
	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic amu_pkg::amu_class_t amu_class(input logic [7:0] op);
		amu_pkg::amu_class_t c;
		c = amu_pkg::C_NOP;
		if (op[7:6] == amu_pkg::OPG_REL) c = amu_pkg::C_REL;
		else if (op[7:4] == amu_pkg::OPG_ABS) c = amu_pkg::C_ABS;
		else if (op[7:4] == amu_pkg::OPG_SHORT) c = amu_pkg::C_SHORT;
		else if (op[7:4] == amu_pkg::OPG_BIT) c = op[3] ? amu_pkg::C_SET : amu_pkg::C_CLR;
		else if (op[7:4] == amu_pkg::OPG_TEST && !op[3]) c = amu_pkg::C_TEST;
		else if (op[7:4] == amu_pkg::OPG_IND && !op[3] && op[2:1] != 2'h3) c = amu_pkg::C_IND;
		else if (op == amu_pkg::OP_LD_DIR) c = amu_pkg::C_DIR;
		else if (op == amu_pkg::OP_LD_IMM) c = amu_pkg::C_IMM;
		else if (op == amu_pkg::OP_TABLE_LOAD) c = amu_pkg::C_TLOAD;
		else if (op == amu_pkg::OP_TABLE_JUMP) c = amu_pkg::C_TJUMP;
		else if (op == amu_pkg::OP_LONG_JUMP) c = amu_pkg::C_LONG;
		else if (op == amu_pkg::OP_LD_SECOND) c = amu_pkg::C_LDX;
		else if (op == amu_pkg::OP_LD_STACK) c = amu_pkg::C_LDSP;
		else if (op == amu_pkg::OP_VECTOR) c = amu_pkg::C_VEC;
		return c;
	endfunction : amu_class

	// Bytes that follow the opcode
	function automatic logic [1:0] amu_extra(input amu_pkg::amu_class_t c);
		case (c)
			amu_pkg::C_LONG: return 2'h2;
			amu_pkg::C_ABS, amu_pkg::C_DIR, amu_pkg::C_IMM, amu_pkg::C_LDX,
			amu_pkg::C_LDSP, amu_pkg::C_SET, amu_pkg::C_CLR, amu_pkg::C_TEST: return 2'h1;
			default: return 2'h0;
		endcase
	endfunction : amu_extra

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	amu_pkg::amu_state_t state_r, state_nxt, ret_r, ret_nxt;
	logic [amu_pkg::PC_W-1:0] pc_nxt, pm_addr_nxt;
	logic [7:0] acc_nxt, op_r, op_nxt, opnd_r, opnd_nxt;
	logic pm_rd_nxt, skip_nxt;
	amu_pkg::amu_dm_req_t dm_req_nxt;
	logic ptr_wr_en;
	logic [1:0] ptr_wr_sel;
	logic [7:0] ptr_wr_data, bit_mask;
	amu_pkg::amu_class_t op_class, cur_class;

	amu_ptr_file u_ptr_file (
		.clk(clk),
		.reset_n(reset_n),
		.wr_en(ptr_wr_en),
		.wr_sel(ptr_wr_sel),
		.wr_data(ptr_wr_data),
		.ptrs_r(ptrs_r)
	);

	assign op_class = amu_class(pm_rdata);
	assign cur_class = amu_class(op_r);
	assign bit_mask = 8'h01 << op_r[2:0];

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		ret_nxt = ret_r;
		pc_nxt = pc_r;
		pm_addr_nxt = pm_addr_r;
		pm_rd_nxt = 1'b0;
		acc_nxt = acc_r;
		op_nxt = op_r;
		opnd_nxt = opnd_r;
		skip_nxt = skip_r;
		dm_req_nxt = dm_req_r;
		dm_req_nxt.rd = 1'b0;
		dm_req_nxt.wr = 1'b0;
		ptr_wr_en = 1'b0;
		ptr_wr_sel = amu_pkg::PTR_FIRST;
		ptr_wr_data = 8'h00;
		case (state_r)
			amu_pkg::S_FETCH: begin
				pm_addr_nxt = pc_r;
				pm_rd_nxt = 1'b1;
				pc_nxt = pc_r + 15'h0001;
				ret_nxt = amu_pkg::S_OP;
				state_nxt = amu_pkg::S_WAIT;
			end
			amu_pkg::S_WAIT: begin
				state_nxt = ret_r;
			end
			amu_pkg::S_OP: begin
				op_nxt = pm_rdata;
				state_nxt = amu_pkg::S_FETCH;
				if (skip_r) begin
					skip_nxt = 1'b0;
					pc_nxt = pc_r + {13'h0000, amu_extra(op_class)};
				end else begin
					case (op_class)
						amu_pkg::C_REL: begin
							pc_nxt = pc_r + {{9{pm_rdata[5]}}, pm_rdata[5:0]};
						end
						amu_pkg::C_SHORT: begin
							ptr_wr_en = 1'b1;
							ptr_wr_sel = amu_pkg::PTR_FIRST;
							ptr_wr_data = {4'h0, pm_rdata[3:0]};
						end
						amu_pkg::C_IND: begin
							dm_req_nxt.addr = pm_rdata[0] ? ptrs_r.second : ptrs_r.first;
							dm_req_nxt.rd = 1'b1;
							ptr_wr_sel = pm_rdata[0] ? amu_pkg::PTR_SECOND : amu_pkg::PTR_FIRST;
							ptr_wr_en = pm_rdata[2:1] != amu_pkg::MOD_NONE;
							ptr_wr_data = (pm_rdata[2:1] == amu_pkg::MOD_INC) ?
								dm_req_nxt.addr + 8'h01 : dm_req_nxt.addr - 8'h01;
							ret_nxt = amu_pkg::S_DREAD;
							state_nxt = amu_pkg::S_WAIT;
						end
						amu_pkg::C_TLOAD, amu_pkg::C_TJUMP: begin
							pm_addr_nxt = {pc_r[14:8], acc_r};
							pm_rd_nxt = 1'b1;
							ret_nxt = amu_pkg::S_TABLE;
							state_nxt = amu_pkg::S_WAIT;
						end
						amu_pkg::C_VEC: begin
							pm_addr_nxt = vector_addr;
							pm_rd_nxt = 1'b1;
							ret_nxt = amu_pkg::S_VEC1;
							state_nxt = amu_pkg::S_WAIT;
						end
						default: begin
							if (amu_extra(op_class) != 2'h0) begin
								pm_addr_nxt = pc_r;
								pm_rd_nxt = 1'b1;
								pc_nxt = pc_r + 15'h0001;
								ret_nxt = amu_pkg::S_OPND;
								state_nxt = amu_pkg::S_WAIT;
							end
						end
					endcase
				end
			end
			amu_pkg::S_OPND: begin
				opnd_nxt = pm_rdata;
				state_nxt = amu_pkg::S_FETCH;
				case (cur_class)
					amu_pkg::C_DIR, amu_pkg::C_SET, amu_pkg::C_CLR, amu_pkg::C_TEST: begin
						dm_req_nxt.addr = pm_rdata;
						dm_req_nxt.rd = 1'b1;
						ret_nxt = (cur_class == amu_pkg::C_DIR) ? amu_pkg::S_DREAD : amu_pkg::S_RMW;
						state_nxt = amu_pkg::S_WAIT;
					end
					amu_pkg::C_IMM: acc_nxt = pm_rdata;
					amu_pkg::C_LDX, amu_pkg::C_LDSP: begin
						ptr_wr_en = 1'b1;
						ptr_wr_sel = (cur_class == amu_pkg::C_LDX) ?
							amu_pkg::PTR_SECOND : amu_pkg::PTR_STACK;
						ptr_wr_data = pm_rdata;
					end
					amu_pkg::C_ABS: pc_nxt = {pc_r[14:12], op_r[3:0], pm_rdata};
					amu_pkg::C_LONG: begin
						pm_addr_nxt = pc_r;
						pm_rd_nxt = 1'b1;
						pc_nxt = pc_r + 15'h0001;
						ret_nxt = amu_pkg::S_OPND2;
						state_nxt = amu_pkg::S_WAIT;
					end
					default: state_nxt = amu_pkg::S_FETCH;
				endcase
			end
			amu_pkg::S_OPND2: begin
				pc_nxt = {opnd_r[6:0], pm_rdata};
				state_nxt = amu_pkg::S_FETCH;
			end
			amu_pkg::S_DREAD: begin
				acc_nxt = dm_rdata;
				state_nxt = amu_pkg::S_FETCH;
			end
			amu_pkg::S_RMW: begin
				state_nxt = amu_pkg::S_FETCH;
				case (cur_class)
					amu_pkg::C_SET: begin
						dm_req_nxt.wr = 1'b1;
						dm_req_nxt.wdata = dm_rdata | bit_mask;
					end
					amu_pkg::C_CLR: begin
						dm_req_nxt.wr = 1'b1;
						dm_req_nxt.wdata = dm_rdata & ~bit_mask;
					end
					default: skip_nxt = (dm_rdata & bit_mask) == 8'h00;
				endcase
			end
			amu_pkg::S_TABLE: begin
				state_nxt = amu_pkg::S_FETCH;
				if (cur_class == amu_pkg::C_TLOAD) begin
					acc_nxt = pm_rdata;
				end else begin
					pc_nxt = {pc_r[14:8], pm_rdata};
				end
			end
			amu_pkg::S_VEC1: begin
				opnd_nxt = pm_rdata;
				pm_addr_nxt = pm_addr_r + 15'h0001;
				pm_rd_nxt = 1'b1;
				ret_nxt = amu_pkg::S_VEC2;
				state_nxt = amu_pkg::S_WAIT;
			end
			amu_pkg::S_VEC2: begin
				pc_nxt = {opnd_r[6:0], pm_rdata};
				state_nxt = amu_pkg::S_FETCH;
			end
			default: state_nxt = amu_pkg::S_FETCH;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= amu_pkg::S_FETCH;
			ret_r <= amu_pkg::S_OP;
			pc_r <= amu_pkg::PC_RST;
			pm_addr_r <= amu_pkg::PC_RST;
			pm_rd_r <= 1'b0;
			acc_r <= amu_pkg::ACC_RST;
			op_r <= 8'h00;
			opnd_r <= 8'h00;
			skip_r <= 1'b0;
			dm_req_r <= '{addr: 8'h00, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
		end else begin
			state_r <= state_nxt;
			ret_r <= ret_nxt;
			pc_r <= pc_nxt;
			pm_addr_r <= pm_addr_nxt;
			pm_rd_r <= pm_rd_nxt;
			acc_r <= acc_nxt;
			op_r <= op_nxt;
			opnd_r <= opnd_nxt;
			skip_r <= skip_nxt;
			dm_req_r <= dm_req_nxt;
		end
	end
endmodule : amu_core
`default_nettype wire

/* test/amu_mem_model.sv */
// Program and data memory model answering one cycle after each strobe
`timescale 1ns/1ps
`default_nettype none
module amu_mem_model (
	// Clock
	input wire logic clk,
	// Program memory side
	input wire logic [14:0] pm_addr_r,
	input wire logic pm_rd_r,
	output logic [7:0] pm_rdata,
	// Data memory side
	input wire amu_pkg::amu_dm_req_t dm_req_r,
	output logic [7:0] dm_rdata
);
	logic [7:0] pm [0:32767];
	logic [7:0] dm [0:255];
	logic [7:0] pq = 8'h00;
	logic [7:0] dq = 8'h00;
	logic pv = 1'b0;
	logic dv = 1'b0;
	always @(posedge clk) begin
		pv <= pm_rd_r;
		dv <= dm_req_r.rd;
		if (pm_rd_r)
			pq <= pm[pm_addr_r];
		if (dm_req_r.rd)
			dq <= dm[dm_req_r.addr];
		if (dm_req_r.wr)
			dm[dm_req_r.addr] <= dm_req_r.wdata;
	end
	// Outside the answer cycle the lines show the inverse
	assign pm_rdata = pv ? pq : ~pq;
	assign dm_rdata = dv ? dq : ~dq;
endmodule : amu_mem_model
`default_nettype wire

/* test/amu_core_chk.sv */
// Concurrent checks on the ports of the addressing mode unit
`timescale 1ns/1ps
`default_nettype none
module amu_core_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Program memory
	input wire logic [amu_pkg::PC_W-1:0] pm_addr_r,
	input wire logic pm_rd_r,
	input wire logic [7:0] pm_rdata,
	// Data memory and vector
	input wire amu_pkg::amu_dm_req_t dm_req_r,
	input wire logic [7:0] dm_rdata,
	input wire logic [amu_pkg::PC_W-1:0] vector_addr,
	// Core state
	input wire logic [amu_pkg::PC_W-1:0] pc_r,
	input wire logic [7:0] acc_r,
	input wire logic skip_r,
	input wire amu_pkg::amu_ptrs_t ptrs_r
);
	logic rd_d_r, rd_d_nxt;
	logic [7:0] cap_r, cap_nxt;
	// Byte returned by the last data read
	always_comb begin
		rd_d_nxt = dm_req_r.rd;
		cap_nxt = rd_d_r ? dm_rdata : cap_r;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_d_r <= 1'b0;
			cap_r <= 8'h00;
		end else begin
			rd_d_r <= rd_d_nxt;
			cap_r <= cap_nxt;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	rst_fetch_a: assert property ($rose(reset_n) |-> pc_r == 15'h0000 && !pm_rd_r
		##1 pm_rd_r && pm_addr_r == 15'h0000) else $error("first fetch not at zero");
	rd_pulse_a: assert property (pm_rd_r |=> !pm_rd_r) else $error("read strobe too long");
	seq_fetch_a: assert property (pm_rd_r && pm_addr_r == $past(pc_r)
		&& acc_r != pm_addr_r[7:0] |-> pc_r == pm_addr_r + 15'h0001) else $error("pc not advanced");
	first_step_a: assert property ($changed(ptrs_r.first) |->
		ptrs_r.first[7:4] == 4'h0 || ptrs_r.first == $past(ptrs_r.first) + 8'h01
		|| ptrs_r.first == $past(ptrs_r.first) - 8'h01) else $error("first pointer bad step");
	stack_load_a: assert property ($changed(ptrs_r.stack) |->
		ptrs_r.stack == $past(pm_rdata) || ptrs_r.stack == $past(pm_rdata, 2))
		else $error("stack pointer bad source");
	wr_addr_a: assert property (dm_req_r.wr |-> $stable(dm_req_r.addr)
		&& ($past(dm_req_r.rd, 2) || $past(dm_req_r.rd, 3))) else $error("write without read");
	bit_modify_a: assert property (dm_req_r.wr |->
		$countones(dm_req_r.wdata ^ cap_r) <= 1) else $error("more than one bit changed");
	acc_src_a: assert property ($changed(acc_r) |->
		acc_r == $past(pm_rdata) || acc_r == $past(dm_rdata)) else $error("accumulator bad source");
	skip_once_a: assert property ($rose(skip_r) |-> $past(rd_d_r) ##3 !skip_r)
		else $error("skip flag not cleared by next instruction");
	cover property (dm_req_r.wr);
	cover property ($rose(skip_r));
	cover property (pm_rd_r && pm_addr_r != $past(pc_r));
endmodule : amu_core_chk
bind amu_core amu_core_chk amu_core_chk_i (.clk(clk), .reset_n(reset_n), .pm_addr_r(pm_addr_r),
	.pm_rd_r(pm_rd_r), .pm_rdata(pm_rdata), .dm_req_r(dm_req_r), .dm_rdata(dm_rdata),
	.vector_addr(vector_addr), .pc_r(pc_r), .acc_r(acc_r), .skip_r(skip_r), .ptrs_r(ptrs_r));
`default_nettype wire

/* test/tb.sv */
// Self-checking bench running short programs through the addressing mode unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [14:0] vector_addr = 15'h0000;
	logic [14:0] pm_addr_r, pc_r;
	logic pm_rd_r, skip_r;
	logic [7:0] pm_rdata, dm_rdata, acc_r;
	amu_pkg::amu_dm_req_t dm_req_r;
	amu_pkg::amu_ptrs_t ptrs_r;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed = 32'hD66CB0A2;
	always #5 clk = ~clk;
	amu_core amu_core_i (.clk(clk), .reset_n(reset_n), .pm_addr_r(pm_addr_r), .pm_rd_r(pm_rd_r),
		.pm_rdata(pm_rdata), .dm_req_r(dm_req_r), .dm_rdata(dm_rdata), .vector_addr(vector_addr),
		.pc_r(pc_r), .acc_r(acc_r), .skip_r(skip_r), .ptrs_r(ptrs_r));
	amu_mem_model amu_mem_model_i (.clk(clk), .pm_addr_r(pm_addr_r), .pm_rd_r(pm_rd_r),
		.pm_rdata(pm_rdata), .dm_req_r(dm_req_r), .dm_rdata(dm_rdata));
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [14:0] rel_dest(input logic [14:0] at, input logic [5:0] v);
		return at + 15'h0001 + {{9{v[5]}}, v};
	endfunction : rel_dest
	// Reset, enter code through a long jump, wait for the halt fetch
	task automatic run(input logic [7:0] code[$], input logic [14:0] at, input logic [14:0] halt);
		int n;
		reset_n = 1'b0;
		amu_mem_model_i.pm[0] = 8'hA6;
		amu_mem_model_i.pm[1] = {1'($random(seed)), at[14:8]};
		amu_mem_model_i.pm[2] = at[7:0];
		foreach (code[i]) amu_mem_model_i.pm[at + 15'(i)] = code[i];
		amu_mem_model_i.pm[halt] = 8'hFF;
		repeat (3) @(negedge clk);
		chk({9'h000, pc_r}, 24'h000000);
		reset_n = 1'b1;
		n = 0;
		while (!(pm_rd_r === 1'b1 && pm_addr_r === halt) && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk({23'h000000, n < 300}, 24'h000001);
	endtask : run
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		logic [7:0] a, b, d, e, x, m0, m1;
		logic [2:0] c, s;
		logic [14:0] t;
		for (int i = 0; i < 32768; i++) amu_mem_model_i.pm[i] = 8'($random(seed));
		for (int i = 0; i < 256; i++) amu_mem_model_i.dm[i] = 8'($random(seed));
		@(negedge clk);
		repeat (6) begin
			a = 8'($random(seed));
			b = 8'($random(seed));
			d = 8'($random(seed));
			e = 8'($random(seed));
			x = 8'($random(seed));
			c = 3'($random(seed));
			s = 3'($random(seed));
			t = {7'($random(seed)), 8'h10};
			run('{8'h94, {4'h5, a[3:0]}, 8'hA8, b, 8'hA9, d, 8'h93}, t, t + 15'h0007);
			chk(ptrs_r, {d, b + 8'h01, 4'h0, a[3:0]});
			chk({16'h0000, acc_r}, {16'h0000, amu_mem_model_i.dm[b]});
			run('{8'h80, d}, t, t + 15'h0002);
			chk({16'h0000, acc_r}, {16'h0000, amu_mem_model_i.dm[d]});
			a[7] = 1'b1;
			run('{8'h81, a, 8'hA4}, t, t + 15'h0003);
			chk({16'h0000, acc_r}, {16'h0000, amu_mem_model_i.pm[{t[14:8], a}]});
			amu_mem_model_i.pm[{t[14:8], a}] = {2'b01, b[5:0]};
			run('{8'h81, a, 8'hA5}, t, {t[14:8], 2'b01, b[5:0]});
			chk({16'h0000, acc_r}, {16'h0000, a});
			run('{{4'h2, e[3:0]}, {1'b1, x[6:0]}}, t, {t[14:12], e[3:0], 1'b1, x[6:0]});
			vector_addr = {t[14:8], 8'hC0};
			amu_mem_model_i.pm[vector_addr] = {c[0], x[6:0]};
			amu_mem_model_i.pm[vector_addr + 15'h0001] = {2'b01, e[5:0]};
			run('{8'hB4}, t, {x[6:0], 2'b01, e[5:0]});
			m0 = amu_mem_model_i.dm[d];
			m0[c] = 1'b1;
			m1 = (e == d) ? m0 : amu_mem_model_i.dm[e];
			m1[b[2:0]] = 1'b0;
			if (e == d)
				m0 = m1;
			run('{{5'h0D, c}, d, {5'h0C, b[2:0]}, e, {5'h0E, s}, d, 8'h81, x}, t, t + 15'h8);
			chk({16'h0000, acc_r}, {16'h0000, m0[s] ? x : 8'h00});
			chk({16'h0000, amu_mem_model_i.dm[e]}, {16'h0000, m1});
			chk({16'h0000, amu_mem_model_i.dm[d]}, {16'h0000, m0});
		end
		// Displacement zero is never issued by software
		for (int v = 1; v < 64; v++) begin
			t = {7'($random(seed)), 8'h40};
			run('{{2'h3, 6'(v)}}, t, rel_dest(t, 6'(v)));
		end
		complete_run();
	end
endmodule : tb
`default_nettype wire
